/* shared/i2mr_map.svh */
// register map, field positions, reset values and timing counts
// assumes a 100 MHz clk; included by the design, the checker and the bench
`ifndef I2MR_MAP_SVH
`define I2MR_MAP_SVH
`define I2MR_ADDR_W        3
`define I2MR_OFF_CTRL      3'h0
`define I2MR_OFF_BUF       3'h1
`define I2MR_OFF_BAUD      3'h2
`define I2MR_OFF_STAT      3'h3
`define I2MR_OFF_MASK      3'h4
`define I2MR_OFF_STATE     3'h5
`define I2MR_CTRL_EN       0
`define I2MR_CTRL_START    1
`define I2MR_CTRL_RCV      3
`define I2MR_CTRL_ACK      4
`define I2MR_CTRL_SLEEP    5
`define I2MR_ST_BYTE       0
`define I2MR_ST_OVF        1
`define I2MR_ST_WRITE_COLLISION_FLAG       2
`define I2MR_ST_BCOL       3
`define I2MR_ST_ACKDONE    4
`define I2MR_BAUD_RST      8'h09
`define I2MR_MASK_RST      8'h00
`define I2MR_BITS_PER_BYTE 4'h8
`endif

/* shared/i2mr_pkg.sv */
// types shared by the i2c master receive block
// assumes i2mr_map.svh for the numeric constants
package i2mr_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_S_CHK  = 4'b0001,
    ST_S_ONE  = 4'b0010,
    ST_S_TWO  = 4'b0011,
    ST_R_LOW  = 4'b0100,
    ST_R_WAIT = 4'b0101,
    ST_R_HIGH = 4'b0110,
    ST_A_LOW  = 4'b0111,
    ST_A_WAIT = 4'b1000,
    ST_A_HIGH = 4'b1001,
    ST_A_END  = 4'b1010
  } i2mr_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } i2mr_req_s;

  typedef struct packed {
    logic ackDone;
    logic busCollision;
    logic writeCollision;
    logic receiveOverflow;
    logic byteDone;
  } i2mr_evt_s;
endpackage : i2mr_pkg

/* hdl/i2mr_master_rx.sv */
// i2c master receive engine: start with collision check, byte reception
// with clock stretching, ack sequence, status, interrupt and wake.
// assumes open-drain pins resolved outside; sclIn/sdaIn are raw pins.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "i2mr_map.svh"

// Notes on behaviour
// - receive starts on enable bit; ignored unless port idle
// - every generator rollover except the one ending the first start count toggles scl; data shifts in on rising scl
// - after eighth falling edge: clear receive bit, load buffer, flags, hold low
// - buffer-full sets whenever the shift register moves into the buffer
// - reading the buffer clears buffer-full
// - overflow sets when a byte completes while buffer-full still set
// - buffer write during shifting sets write collision, write dropped
// - after releasing scl the generator waits until scl samples high
// - on scl high the generator reloads from low seven baud bits
// - scl high phase lasts at least one full generator rollover
// - in sleep the port keeps receiving and wakes cpu if enabled
// - any reset disables the port and aborts the transfer
// - sda or scl low at start: abort, set bus collision, go idle
// - start: lines released, count from baud; scl low with sda high collides
// - sda low during first count: reset generator, drive sda low now
// - second count after sda low; scl low then is fine; then pull scl low
module i2mr_master_rx
  import i2mr_pkg::*;
#(
  parameter int BYTE_BITS = 8
)(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    wr,
  input  wire logic                    rd,
  input  wire logic [`I2MR_ADDR_W-1:0] addr,
  input  wire logic [7:0]              wdata,
  output logic      [7:0]              rdata,
  input  wire logic                    sclIn,
  output logic                         sclOut,
  output logic                         sclOe,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe,
  output logic                         irq,
  output logic                         wake
);

  i2mr_state_e state;
  i2mr_state_e next_state;
  i2mr_req_s   req;
  i2mr_evt_s   evt;

  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [7:0] ctrl;
  logic [7:0] baud;
  logic [7:0] dataBuf;
  logic [7:0] shiftReg;
  logic [4:0] status;
  logic [4:0] mask;
  logic       bufFull;
  logic [6:0] baud_rate_generator;
  logic [3:0] bitCnt;
  logic       sclLow;
  logic       sdaLow;

  // only the second stage is read
  wire sclHi = sclSync[1];
  wire sdaHi = sdaSync[1];

  assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  wire portEn   = ctrl[`I2MR_CTRL_EN];
  wire rcvReq   = ctrl[`I2MR_CTRL_RCV];
  wire startReq = ctrl[`I2MR_CTRL_START];
  wire ackReq   = ctrl[`I2MR_CTRL_ACK];
  wire asleep   = ctrl[`I2MR_CTRL_SLEEP];
  wire brgZero  = (baud_rate_generator == 7'h00);
  wire isIdle   = (state == ST_IDLE);
  wire shifting = (state == ST_R_LOW) || (state == ST_R_WAIT) ||
                  (state == ST_R_HIGH);

  wire wrCtrl  = req.wr && (req.addr == `I2MR_OFF_CTRL);
  wire wrBuf   = req.wr && (req.addr == `I2MR_OFF_BUF);
  wire wrBaud  = req.wr && (req.addr == `I2MR_OFF_BAUD);
  wire wrStat  = req.wr && (req.addr == `I2MR_OFF_STAT);
  wire wrMask  = req.wr && (req.addr == `I2MR_OFF_MASK);
  wire rdBuf   = req.rd && (req.addr == `I2MR_OFF_BUF);

  // state decisions
  wire goRecv    = portEn && isIdle && rcvReq;
  wire goStart   = portEn && isIdle && startReq && !rcvReq;
  wire goAck     = portEn && isIdle && ackReq && !rcvReq && !startReq;
  wire startBad  = (state == ST_S_CHK) && (!sdaHi || !sclHi);
  wire startCol  = (state == ST_S_ONE) && sdaHi && !sclHi;
  wire startEarly = (state == ST_S_ONE) && !sdaHi;
  wire lastFall  = (state == ST_R_HIGH) && brgZero &&
                   (bitCnt == BYTE_BITS[3:0] - 4'h1);
  wire sampleBit = (state == ST_R_WAIT) && sclHi;

  assign evt.byteDone        = lastFall;
  assign evt.receiveOverflow = lastFall && bufFull;
  assign evt.writeCollision  = wrBuf && shifting;
  assign evt.busCollision    = startBad || startCol;
  assign evt.ackDone         = (state == ST_A_END);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (goRecv) next_state = ST_R_LOW;
        else if (goStart) next_state = ST_S_CHK;
        else if (goAck) next_state = ST_A_LOW;
      ST_S_CHK:
        next_state = startBad ? ST_IDLE : ST_S_ONE;
      ST_S_ONE:
        if (startCol) next_state = ST_IDLE;
        else if (startEarly || brgZero) next_state = ST_S_TWO;
      ST_S_TWO:
        if (brgZero) next_state = ST_IDLE;
      ST_R_LOW:
        if (brgZero) next_state = ST_R_WAIT;
      ST_R_WAIT:
        if (sclHi) next_state = ST_R_HIGH;
      ST_R_HIGH:
        if (lastFall) next_state = ST_IDLE;
        else if (brgZero) next_state = ST_R_LOW;
      ST_A_LOW:
        if (brgZero) next_state = ST_A_WAIT;
      ST_A_WAIT:
        if (sclHi) next_state = ST_A_HIGH;
      ST_A_HIGH:
        if (brgZero) next_state = ST_A_END;
      ST_A_END:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
    if (!portEn)
      next_state = ST_IDLE;
  end

  // generator reload: each phase begins from the low seven baud bits
  wire brgLoad = (next_state != state) || startEarly ||
                 (state == ST_R_WAIT) || (state == ST_A_WAIT);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
    end
    else
    begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      baud_rate_generator   <= 7'h00;
    end
    else
    begin
      state <= next_state;
      // waiting states hold the count until scl is seen high
      if (brgLoad)
        baud_rate_generator <= baud[6:0];
      else if (!brgZero)
        baud_rate_generator <= baud_rate_generator - 7'h01;
    end
  end

  // shifting on sampled rising scl; bit counter steps on each scl fall before the last
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
    end
    else if (goRecv)
    begin
      bitCnt <= 4'h0;
    end
    else if (sampleBit)
    begin
      shiftReg <= {shiftReg[6:0], sdaHi};
    end
    else if ((state == ST_R_HIGH) && brgZero && !lastFall)
    begin
      bitCnt <= bitCnt + 4'h1;
    end
  end

  // open-drain drive: only low or released
  // the eighth fall leaves scl held low until the next command
  wire next_sclLow = (state == ST_S_TWO && brgZero) ||
                     lastFall ||
                     ((next_state == ST_R_LOW) ||
                      (next_state == ST_A_LOW) ||
                      (next_state == ST_A_END) ||
                      (next_state == ST_IDLE && sclLow && portEn)) &&
                     !(next_state == ST_IDLE && evt.busCollision);
  wire next_sdaLow = (next_state == ST_S_TWO) ||
                     (state == ST_S_TWO && !brgZero) ||
                     (next_state == ST_A_LOW) ||
                     (next_state == ST_A_WAIT) ||
                     (next_state == ST_A_HIGH) ||
                     (next_state == ST_A_END) ||
                     (sdaLow && next_state == ST_IDLE && portEn &&
                      state == ST_S_TWO);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclLow <= 1'b0;
      sdaLow <= 1'b0;
    end
    else
    begin
      sclLow <= next_sclLow;
      sdaLow <= next_sdaLow;
    end
  end

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = sclLow;
  assign sdaOe  = sdaLow;

  // control bits: hardware clear of start/ack once taken, of receive at the eighth fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= 8'h00;
      baud <= `I2MR_BAUD_RST;
      mask <= 5'(`I2MR_MASK_RST);
    end
    else
    begin
      if (wrCtrl)
        ctrl <= req.wdata;
      else
      begin
        if (lastFall || (isIdle && rcvReq && !portEn))
          ctrl[`I2MR_CTRL_RCV] <= 1'b0;
        if (!isIdle && state != ST_R_LOW && rcvReq && !shifting)
          ctrl[`I2MR_CTRL_RCV] <= 1'b0;
        if (goStart || (startReq && !isIdle))
          ctrl[`I2MR_CTRL_START] <= 1'b0;
        if (goAck || (ackReq && !isIdle))
          ctrl[`I2MR_CTRL_ACK] <= 1'b0;
      end
      if (wrBaud)
        baud <= req.wdata;
      if (wrMask)
        mask <= req.wdata[4:0];
    end
  end

  // buffer, buffer-full and sticky status; set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataBuf <= 8'h00;
      bufFull <= 1'b0;
      status  <= 5'h00;
    end
    else
    begin
      if (lastFall)
        dataBuf <= shiftReg;
      else if (wrBuf && !shifting)
        dataBuf <= req.wdata;
      if (lastFall)
        bufFull <= 1'b1;
      else if (rdBuf)
        bufFull <= 1'b0;
      // software clears by writing one
      status <= (status & ~(wrStat ? req.wdata[4:0] : 5'h00)) | evt;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 8'h00;
      irq   <= 1'b0;
      wake  <= 1'b0;
    end
    else
    begin
      unique case (req.addr)
        `I2MR_OFF_CTRL:  rdata <= ctrl;
        `I2MR_OFF_BUF:   rdata <= dataBuf;
        `I2MR_OFF_BAUD:  rdata <= baud;
        `I2MR_OFF_STAT:  rdata <= {2'h0, bufFull, status};
        `I2MR_OFF_MASK:  rdata <= {3'h0, mask};
        `I2MR_OFF_STATE: rdata <= {4'h0, state};
        default:         rdata <= 8'h00;
      endcase
      irq  <= |(status & mask);
      // reception keeps running in sleep; a finished byte wakes the cpu
      // taken from the stored flag so wake never runs ahead of irq
      wake <= asleep && mask[`I2MR_ST_BYTE] &&
              status[`I2MR_ST_BYTE];
    end
  end

endmodule : i2mr_master_rx
`default_nettype wire

/* test/i2mr_master_rx_asserts.sv */
// pin and register-port checks for the i2c master receive block
// assumes a bind onto i2mr_master_rx, sharing its clk and rst_n
`timescale 1ns/1ps
`default_nettype none
`include "i2mr_map.svh"
module i2mr_master_rx_asserts
  import i2mr_pkg::*;
#(
  parameter int BYTE_BITS = 8
)(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       irq,
  input wire logic       wake
);
  logic [6:0] baud;
  logic [7:0] highCnt;
  // raw pin view; the design sees it two flops later, so this bounds it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baud    <= 7'(`I2MR_BAUD_RST);
      highCnt <= 8'h00;
    end
    else
    begin
      if (wr && addr == `I2MR_OFF_BAUD)
        baud <= wdata[6:0];
      if (!sclIn)
        highCnt <= 8'h00;
      else if (highCnt != 8'hff)
        highCnt <= highCnt + 8'h01;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_OPEN_DRAIN: assert property (!sclOut && !sdaOut)
    else $error("pin output not low");
  AST_RESET_QUIET: assert property ($rose(rst_n) |->
    !sclOe && !sdaOe && !irq && !wake) else $error("busy after reset");
  AST_BUF_CLEAR: assert property ((rd && addr == `I2MR_OFF_BUF)
    ##1 (rd && addr == `I2MR_OFF_STAT) |=> !rdata[5])
    else $error("buffer full kept after read");
  AST_SCL_HIGH: assert property ($rose(sclOe) |->
    highCnt >= {1'b0, baud} + 8'h01) else $error("scl high too short");
  AST_START_ORDER: assert property ($rose(sdaOe) && !sclOe |->
    (!sclOe) [*5] ##[1:300] sclOe) else $error("start timing");
  AST_COLLISION: assert property ((wr && addr == `I2MR_OFF_CTRL
    && wdata[1] && !sdaIn && !sdaOe) ##1 (!sdaIn) [*4]
    |=> (!sdaOe && !sclOe) [*8]) else $error("start not aborted");
  AST_IRQ_MASK: assert property ((wr && addr == `I2MR_OFF_MASK
    && wdata == 8'h00) |-> ##2 !irq) else $error("irq while masked");
  AST_WAKE: assert property (wake |-> irq)
    else $error("wake without interrupt");
endmodule : i2mr_master_rx_asserts
`default_nettype wire

/* test/i2mr_slave_model.sv */
// far side: a slave sending one byte msb first, able to stretch scl
// assumes the bench resolves scl and sda with pull-ups
`timescale 1ns/1ps
`default_nettype none
module i2mr_slave_model (
  input  wire logic       clk,
  input  wire logic       active,
  input  wire logic       busyLow,
  input  wire logic [3:0] stretch,
  input  wire logic [7:0] txByte,
  input  wire logic       scl,
  output var  logic       sclLow,
  output var  logic       sdaLow
);
  logic [3:0] idx     = 4'h0;
  logic [3:0] hold    = 4'h0;
  logic       sclPrev = 1'b1;
  always @(posedge clk)
  begin
    sclPrev <= scl;
    if (!active)
      idx <= 4'h0;
    else if (sclPrev && !scl)
      idx <= idx + 4'h1;
    if (active && sclPrev && !scl)
      hold <= stretch;
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
  end
  assign sclLow = hold != 4'h0;
  // released after the eighth bit so the pull-up takes the line
  assign sdaLow = busyLow || (active && idx < 4'h8
                  && !txByte[3'h7 - idx[2:0]]);
endmodule : i2mr_slave_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench: reads are queued with their expected value
// assumes the receive block, its checker and the slave model
`timescale 1ns/1ps
`default_nettype none
`include "i2mr_map.svh"
module tb;
  import i2mr_pkg::*;
  logic        clk;
  logic        rst_n   = 1'b0;
  i2mr_req_s   req     = '0;
  logic [7:0]  rdata;
  logic        sclOe, sdaOe, sclOut, sdaOut, irq, wake, sclLow, sdaLow;
  logic        active  = 1'b0;
  logic        busyLow = 1'b0;
  logic        rdPend  = 1'b0;
  logic [3:0]  stretch = 4'h0;
  logic [7:0]  txByte  = 8'h00;
  logic [31:0] seed    = 32'd81;
  logic [7:0]  expQ[$];
  int          miscompares = 0;
  int          check_count = 0;
  wire logic   scl = ~(sclOe | sclLow);
  wire logic   sda = ~(sdaOe | sdaLow);
  i2mr_master_rx i_dut (.clk, .rst_n, .wr(req.wr), .rd(req.rd),
    .addr(req.addr), .wdata(req.wdata), .rdata, .sclIn(scl), .sclOut,
    .sclOe, .sdaIn(sda), .sdaOut, .sdaOe, .irq, .wake);
  i2mr_slave_model i_slave (.clk, .active, .busyLow, .stretch, .txByte,
    .scl, .sclLow, .sdaLow);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // a read carries its expected value in d
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    if (!w)
      expQ.push_back(d);
  endtask : bus
  task automatic idle(input int n);
    @(posedge clk);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask : idle
  // two idle edges first so a just-cleared irq has dropped
  task automatic waitIrq;
    int i;
    idle(2);
    for (i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge clk);
    if (irq !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
  endtask : waitIrq
  task automatic recv(input logic [7:0] ctl, input logic [3:0] st);
    @(posedge clk);
    req    <= '0;
    active <= 1'b0;
    seed = xs(seed);
    @(posedge clk);
    txByte  <= seed[7:0];
    stretch <= st;
    active  <= 1'b1;
    bus(1'b1, `I2MR_OFF_CTRL, ctl);
  endtask : recv
  always @(posedge clk)
  begin
    if (rdPend)
      chk("rdata", expQ.pop_front(), rdata);
    rdPend <= req.rd && rst_n;
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, `I2MR_OFF_BAUD, `I2MR_BAUD_RST);
    bus(1'b0, `I2MR_OFF_MASK, `I2MR_MASK_RST);
    bus(1'b1, 3'h7, 8'hff);
    bus(1'b0, 3'h7, 8'h00);
    bus(1'b1, `I2MR_OFF_BAUD, 8'h05);
    bus(1'b1, `I2MR_OFF_MASK, 8'h19);
    busyLow <= 1'b1;
    bus(1'b1, `I2MR_OFF_CTRL, 8'h03);
    waitIrq();
    bus(1'b0, `I2MR_OFF_STAT, 8'h08);
    bus(1'b1, `I2MR_OFF_STAT, 8'hff);
    busyLow <= 1'b0;
    bus(1'b1, `I2MR_OFF_CTRL, 8'h03);
    idle(30);
    recv(8'h29, 4'h0);
    idle(20);
    bus(1'b1, `I2MR_OFF_BUF, 8'h5a);
    waitIrq();
    chk("wake", 8'h01, {7'h00, wake});
    bus(1'b0, `I2MR_OFF_STAT, 8'h25);
    bus(1'b0, `I2MR_OFF_BUF, txByte);
    bus(1'b0, `I2MR_OFF_STAT, 8'h05);
    bus(1'b1, `I2MR_OFF_STAT, 8'hff);
    bus(1'b1, `I2MR_OFF_CTRL, 8'h11);
    waitIrq();
    bus(1'b0, `I2MR_OFF_STAT, 8'h10);
    bus(1'b1, `I2MR_OFF_STAT, 8'hff);
    recv(8'h09, 4'hf);
    waitIrq();
    bus(1'b0, `I2MR_OFF_STAT, 8'h21);
    bus(1'b1, `I2MR_OFF_STAT, 8'h01);
    recv(8'h09, 4'h0);
    waitIrq();
    bus(1'b0, `I2MR_OFF_STAT, 8'h23);
    bus(1'b1, `I2MR_OFF_MASK, 8'h00);
    idle(3);
    chk("irq", 8'h00, {7'h00, irq});
    conclude();
  end
endmodule
bind i2mr_master_rx i2mr_master_rx_asserts #(.BYTE_BITS(BYTE_BITS)) i_chk (
  .clk, .rst_n, .wr, .rd, .addr, .wdata, .rdata, .sclIn, .sclOut, .sclOe,
  .sdaIn, .sdaOut, .sdaOe, .irq, .wake);
`default_nettype wire
